// [include/ltd_cfg.svh]
// Offsets, field positions, codes and reset values of the diagnostic register bank
`ifndef LTD_CFG_SVH
`define LTD_CFG_SVH

// Control byte register select field
`define LTD_SEL_LSB        0
`define LTD_SEL_MSB        1
`define LTD_SEL_DIAG       2'h2
// Loopback field
`define LTD_LOOP_LSB       2
`define LTD_LOOP_MSB       3
// Forced default select, default mode choice
`define LTD_FORCE_LSB      4
`define LTD_FORCE_MSB      7
`define LTD_FORCE_ALL      4'hf
`define LTD_DEFSEL_BIT     3
// Single control bits
`define LTD_SWAP_BIT       5
`define LTD_DLO_BIT        6
`define LTD_UNUSED_BIT     7
// Reset value of the diagnostic register
`define LTD_DIAG_RESET     8'h00
// Bits in one control byte
`define LTD_BYTE_BITS      4'h8

`endif

// [include/ltd_pkg.sv]
// Types shared by the diagnostic register bank
package ltd_pkg;

  // Loopback path selection, in field code order
  typedef enum logic [1:0] {
    LTD_LOOP_NONE,
    LTD_LOOP_SYS_IN_OUT,
    LTD_LOOP_LINE,
    LTD_LOOP_END_TO_END
  } ltd_loop_t;

  // Operating mode of the bank
  typedef enum logic [1:0] {
    LTD_MODE_NORMAL,
    LTD_MODE_DEFAULT1,
    LTD_MODE_DEFAULT2
  } ltd_mode_t;

endpackage

// [logic/ltd_byte_rx.sv]
// Control channel byte receiver: pin synchronisers and serial-to-parallel shift
`timescale 1ns/1ps
`include "ltd_cfg.svh"

module ltd_byte_rx (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Control channel pins
  input  wire logic       ctlBitClk,
  input  wire logic       ctlFrame,
  input  wire logic       ctlData,
  // Received byte and synchronised data level
  output logic [7:0]      rxByte,
  output logic            rxValid,
  output logic            dataLevel
);

  logic [2:0] syncA;       // First synchroniser stage
  logic [2:0] syncB;       // Second synchroniser stage
  logic       bitClkLast;  // Previous synced bit clock
  logic [3:0] bitCount;    // Bits taken in this byte
  logic [7:0] shiftReg;    // Byte being assembled
  logic       bitTake;     // Rising bit clock inside a frame

  // Two stages for clock, frame and data pins
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
    end else begin
      syncA <= {ctlBitClk, ctlFrame, ctlData};
      syncB <= syncA;
    end
  end

  // Edge history taken from the second stage only
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bitClkLast <= 1'h0;
    end else begin
      bitClkLast <= syncB[2];
    end
  end

  assign bitTake   = syncB[2] & ~bitClkLast & syncB[1];
  assign dataLevel = syncB[0];

  // Shift bits in, bit 0 first; frame low restarts the byte
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bitCount <= 4'h0;
      shiftReg <= 8'h00;
    end else if (!syncB[1]) begin
      bitCount <= 4'h0;
    end else if (bitTake) begin
      shiftReg <= {syncB[0], shiftReg[7:1]};
      bitCount <= (bitCount == `LTD_BYTE_BITS - 4'h1) ? 4'h0 : bitCount + 4'h1;
    end
  end

  // Whole byte handed over for one cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rxByte  <= 8'h00;
      rxValid <= 1'h0;
    end else begin
      rxValid <= bitTake && (bitCount == `LTD_BYTE_BITS - 4'h1);
      if (bitTake && (bitCount == `LTD_BYTE_BITS - 4'h1)) begin
        rxByte <= {syncB[0], shiftReg[7:1]};
      end
    end
  end

endmodule

// [logic/ltd_diag_reg.sv]
// Diagnostic configuration register of the line transceiver
`timescale 1ns/1ps
`include "ltd_cfg.svh"

module ltd_diag_reg (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Serial control channel pins
  input  wire logic ctlBitClk,
  input  wire logic ctlFrame,
  input  wire logic control_serial_input_pin,
  // Strap: dual port operation
  input  wire logic dualPortMode,
  // Transmit symbol from the line coder
  input  wire logic txSymbol,
  // Loopback path enables
  output logic      loopSysInToSysOut,
  output logic      loopLineOutToLineIn,
  output logic      loopSysOutToSysIn,
  // Scrambler and line driver control
  output logic      polynomial_interchange,
  output logic      line_output_disable,
  output logic      lineTxSymbol,
  output logic      line_bias_level,
  // Default mode state and forced settings
  output logic      defaultModeActive,
  output logic      defaultModeTwo,
  output logic      lineRate160,
  output logic      convergence_speedup,
  output logic      scrambler_enable,
  output logic      d_channel_in_b_slot,
  output logic      diag_register_reset,
  output logic      transmit_housekeeping_bit
);

  logic [7:0]         rxByte;       // Byte from the control channel
  logic               rxValid;      // Byte complete pulse
  logic               pinLevel;     // Synced control input level
  logic               dualSyncA;    // Dual port strap, stage one
  logic               dualSync;     // Dual port strap, stage two
  logic [7:0]         diagValue;    // Stored diagnostic register
  ltd_pkg::ltd_mode_t mode;         // Current operating mode
  ltd_pkg::ltd_mode_t next_mode;    // Mode from register and strap
  ltd_pkg::ltd_loop_t loopSel;      // Loopback field with its two bits swapped
  logic               diagWrite;    // Byte addresses this register

  // Address match on the select bits
  function automatic logic isDiagByte(input logic [7:0] b);
    isDiagByte = (b[`LTD_SEL_MSB:`LTD_SEL_LSB] == `LTD_SEL_DIAG);
  endfunction

  // Forced default pattern in the upper nibble
  function automatic logic isForced(input logic [7:0] b);
    isForced = (b[`LTD_FORCE_MSB:`LTD_FORCE_LSB] == `LTD_FORCE_ALL);
  endfunction

  // Serial byte receiver
  ltd_byte_rx u_rx (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .ctlBitClk (ctlBitClk),
    .ctlFrame  (ctlFrame),
    .ctlData   (control_serial_input_pin),
    .rxByte    (rxByte),
    .rxValid   (rxValid),
    .dataLevel (pinLevel)
  );

  // Dual port strap synchroniser
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dualSyncA <= 1'h0;
      dualSync  <= 1'h0;
    end else begin
      dualSyncA <= dualPortMode;
      dualSync  <= dualSyncA;
    end
  end

  // select bits decode
  // Serial writes only in single port use
  assign diagWrite = rxValid && isDiagByte(rxByte) && !dualSync;

  // store on complete byte
  // Bit 7 kept as written; host sets it only in the forced pattern
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      diagValue <= `LTD_DIAG_RESET;
    end else if (diagWrite) begin
      diagValue <= rxByte;
    end
  end

  // Mode from strap or forced pattern
  always_comb begin
    next_mode = ltd_pkg::LTD_MODE_NORMAL;
    if (dualSync) begin
      next_mode = pinLevel ? ltd_pkg::LTD_MODE_DEFAULT2 : ltd_pkg::LTD_MODE_DEFAULT1;
    end else if (isForced(diagValue)) begin
      next_mode = diagValue[`LTD_DEFSEL_BIT] ? ltd_pkg::LTD_MODE_DEFAULT2 : ltd_pkg::LTD_MODE_DEFAULT1;
    end
  end

  // Mode register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode <= ltd_pkg::LTD_MODE_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  // Bit 2 is the first code digit, bit 3 the second
  assign loopSel = ltd_pkg::ltd_loop_t'({diagValue[`LTD_LOOP_LSB], diagValue[`LTD_LOOP_MSB]});

  // Diagnostic outputs; all cleared in a default mode
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      loopSysInToSysOut      <= 1'h0;
      loopLineOutToLineIn    <= 1'h0;
      loopSysOutToSysIn      <= 1'h0;
      polynomial_interchange <= 1'h0;
      line_output_disable    <= 1'h0;
    end else begin
      case (next_mode)
        ltd_pkg::LTD_MODE_NORMAL: begin
          loopSysInToSysOut      <= (loopSel == ltd_pkg::LTD_LOOP_SYS_IN_OUT);
          loopLineOutToLineIn    <= (loopSel == ltd_pkg::LTD_LOOP_LINE);
          loopSysOutToSysIn      <= (loopSel == ltd_pkg::LTD_LOOP_END_TO_END);
          polynomial_interchange <= diagValue[`LTD_SWAP_BIT];
          line_output_disable    <= diagValue[`LTD_DLO_BIT];
        end
        default: begin
          loopSysInToSysOut      <= 1'h0;
          loopLineOutToLineIn    <= 1'h0;
          loopSysOutToSysIn      <= 1'h0;
          polynomial_interchange <= 1'h0;
          line_output_disable    <= 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lineTxSymbol    <= 1'h0;
      line_bias_level <= 1'h1;
    end else begin
      lineTxSymbol    <= (next_mode == ltd_pkg::LTD_MODE_NORMAL && diagValue[`LTD_DLO_BIT]) ? 1'h0 : txSymbol;
      line_bias_level <= (next_mode == ltd_pkg::LTD_MODE_NORMAL && diagValue[`LTD_DLO_BIT]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      defaultModeActive         <= 1'h0;
      defaultModeTwo            <= 1'h0;
      lineRate160               <= 1'h0;
      convergence_speedup       <= 1'h0;
      scrambler_enable          <= 1'h0;
      d_channel_in_b_slot       <= 1'h0;
      diag_register_reset       <= 1'h0;
      transmit_housekeeping_bit <= 1'h0;
    end else begin
      defaultModeActive         <= (next_mode != ltd_pkg::LTD_MODE_NORMAL);
      defaultModeTwo            <= (next_mode == ltd_pkg::LTD_MODE_DEFAULT2);
      lineRate160               <= (next_mode == ltd_pkg::LTD_MODE_DEFAULT2);
      convergence_speedup       <= 1'h0;
      scrambler_enable          <= 1'h0;
      d_channel_in_b_slot       <= 1'h0;
      diag_register_reset       <= 1'h0;
      transmit_housekeeping_bit <= 1'h0;
    end
  end

  // Checks on the register bank
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Byte write to this register, strap not set
  sequence seqDiagWrite;
    rxValid && isDiagByte(rxByte) && !dualSync;
  endsequence

  // Forced pattern stored
  sequence seqForced;
    !dualSync && isForced(diagValue);
  endsequence

  AST_STORE_ON_BYTE: assert property (seqDiagWrite |=> diagValue == $past(rxByte))
    else $error("Diagnostic byte not stored");
  AST_NO_STRAY_WRITE: assert property (!diagWrite |=> $stable(diagValue))
    else $error("Register changed without a selecting byte");
  AST_STRAP_LOW: assert property (dualSync && !pinLevel |=> defaultModeActive && !defaultModeTwo)
    else $error("Strap low did not give default mode one");
  AST_STRAP_HIGH: assert property (dualSync && pinLevel |=> defaultModeActive && lineRate160)
    else $error("Strap high did not give default mode two");
  AST_LOOP_DECODE: assert property (
    next_mode == ltd_pkg::LTD_MODE_NORMAL && diagValue[`LTD_LOOP_LSB] && !diagValue[`LTD_LOOP_MSB]
    |=> loopLineOutToLineIn && !loopSysInToSysOut && !loopSysOutToSysIn)
    else $error("Line loopback decode wrong");
  AST_LOOP_ONEHOT: assert property ($onehot0({loopSysInToSysOut, loopLineOutToLineIn, loopSysOutToSysIn}))
    else $error("More than one loopback path enabled");
  AST_SWAP: assert property (
    !dualSync && !isForced(diagValue)
    |=> polynomial_interchange == $past(diagValue[`LTD_SWAP_BIT]))
    else $error("Polynomial swap does not follow register");
  AST_BIAS_HOLD: assert property (line_output_disable |-> line_bias_level && !lineTxSymbol)
    else $error("Line output not at bias while disabled");
  AST_FORCED_MODE: assert property (
    seqForced |=> defaultModeActive && defaultModeTwo == $past(diagValue[`LTD_DEFSEL_BIT]))
    else $error("Forced pattern did not select default mode");
  AST_DEFAULT_OFF: assert property (
    defaultModeActive |-> !scrambler_enable && !convergence_speedup
    && !line_output_disable && !polynomial_interchange
    && !transmit_housekeeping_bit)
    else $error("Feature left on in default mode");
  AST_WRITE_TO_MODE: assert property (seqDiagWrite ##1 seqForced |=> defaultModeActive[*2])
    else $error("Forced write not held as default mode");

endmodule

// [testbench/ltd_host_model.sv]
// Host model that writes the serial control channel bit by bit
`timescale 1ns/1ps

module ltd_host_model (
  // Clock
  input  wire logic mclk,
  // Control channel pins
  output logic      ctlBitClk,
  output logic      ctlFrame,
  output logic      ctlData
);
  // Pins idle: bit clock still, window closed
  initial begin
    ctlBitClk = 1'b0;
    ctlFrame  = 1'b0;
    ctlData   = 1'b0;
  end

  // Hold pin levels for a number of cycles, moving only after falling edges
  task automatic hold(input int hp);
    repeat (hp) @(negedge mclk);
  endtask

  // One window of nbits, bit 0 first; hp sets a prompt or slow bit clock
  task automatic send(input logic [15:0] d, input int nbits, input int hp);
    int i;
    @(negedge mclk);
    ctlFrame = 1'b1;
    for (i = 0; i < nbits; i++) begin
      // select bits lead each whole byte
      ctlData   = d[i];
      hold(hp);
      ctlBitClk = 1'b1;
      hold(hp);
      ctlBitClk = 1'b0;
    end
    hold(hp);
    ctlFrame = 1'b0;
    // Released data line shows the inverse of its last bit
    ctlData  = ~ctlData;
  endtask

  // Strap use: data pin held at a fixed level
  task automatic tie(input logic lvl);
    @(negedge mclk);
    ctlData = lvl;
  endtask
endmodule

// [testbench/tb_ltd_diag_reg.sv]
// Self-checking bench for the diagnostic register bank
`timescale 1ns/1ps

module tb_ltd_diag_reg;
  // Clock, reset, strap and line symbol
  logic        mclk;
  logic        rst_b;
  logic        dualPortMode;
  logic        txSymbol;
  // Control channel from the host model
  wire logic   ctlBitClk;
  wire logic   ctlFrame;
  wire logic   ctlData;
  // All outputs gathered in one vector
  wire logic [14:0] obs;
  // Expected state: active, two, three loop paths, swap, disable
  logic [6:0]  expSt;
  logic [7:0]  b;
  logic [31:0] seed;
  int          miscompares;
  int          checked;
  // Hand-written corner bytes, run in order
  logic [7:0]  corner [0:14] = '{8'h0a, 8'h06, 8'h0e, 8'h01, 8'h03, 8'h00, 8'h22, 8'h42,
                                 8'h12, 8'h72, 8'hf2, 8'hfe, 8'hf6, 8'hfa, 8'h02};

  // Host side of the control channel
  ltd_host_model u_host (.mclk(mclk), .ctlBitClk(ctlBitClk), .ctlFrame(ctlFrame), .ctlData(ctlData));

  // Device under test
  ltd_diag_reg u_dut (
    .mclk(mclk), .rst_b(rst_b), .ctlBitClk(ctlBitClk), .ctlFrame(ctlFrame),
    .control_serial_input_pin(ctlData), .dualPortMode(dualPortMode), .txSymbol(txSymbol),
    .loopSysInToSysOut(obs[14]), .loopLineOutToLineIn(obs[13]), .loopSysOutToSysIn(obs[12]),
    .polynomial_interchange(obs[11]), .line_output_disable(obs[10]), .lineTxSymbol(obs[9]),
    .line_bias_level(obs[8]), .defaultModeActive(obs[7]), .defaultModeTwo(obs[6]),
    .lineRate160(obs[5]), .convergence_speedup(obs[4]), .scrambler_enable(obs[3]),
    .d_channel_in_b_slot(obs[2]), .diag_register_reset(obs[1]), .transmit_housekeeping_bit(obs[0]));

  // Clock at 8 ns
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Random line symbol each falling edge
  always @(negedge mclk) begin
    txSymbol <= 1'($random(seed));
  end

  // State after one written byte
  function automatic logic [6:0] next_st(input logic [6:0] st, input logic [7:0] v);
    if (v[1:0] != 2'b10) return st;
    if (v[7:4] == 4'hf) return {1'b1, v[3], 5'h00};
    return {2'b00, ~v[2] & v[3], v[2] & ~v[3], v[2] & v[3], v[5], v[6]};
  endfunction

  // Outputs implied by a state and the symbol last sampled
  function automatic logic [14:0] expect_out(input logic [6:0] st, input logic tx);
    return {st[4], st[3], st[2], st[1], st[0], tx & ~st[0], st[0], st[6], st[5], st[5], 5'h00};
  endfunction

  // One comparison of all outputs against a state
  task automatic check(input logic [6:0] st);
    checked++;
    if (obs !== expect_out(st, txSymbol)) begin
      miscompares++;
      $display("BAD %0t outputs %h expected %h", $time, obs, expect_out(st, txSymbol));
    end
  endtask

  // Let a write land, then compare over a few cycles
  task automatic settle;
    repeat (8) @(negedge mclk);
    repeat (3) begin
      @(negedge mclk);
      check(expSt);
    end
  endtask

  // Write one byte at a random bit clock speed
  task automatic apply(input logic [7:0] v);
    int hp;
    hp = 3 + ({$random(seed)} % 4);
    u_host.send({8'h00, v}, 8, hp);
    expSt = next_st(expSt, v);
    settle();
  endtask

  // Verdict and end of run
  task automatic complete_run;
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (50000) @(posedge mclk);
    miscompares++;
    complete_run();
  end

  // Main sequence
  initial begin
    seed         = 32'ha988d1fe;
    rst_b        = 1'b0;
    dualPortMode = 1'b0;
    txSymbol     = 1'b0;
    miscompares  = 0;
    checked      = 0;
    expSt        = 7'h00;
    repeat (6) @(negedge mclk);
    checked++;
    // Line held at bias during reset
    if (obs !== 15'h0100) begin
      miscompares++;
      $display("BAD %0t reset outputs %h", $time, obs);
    end
    rst_b = 1'b1;
    settle();
    foreach (corner[i]) begin
      apply(corner[i]);
    end
    // Partial byte dropped, then a full one
    u_host.send(16'h00fa, 4, 3);
    apply(8'h0e);
    // Two bytes back to back in one window
    u_host.send(16'h420a, 16, 3);
    expSt = next_st(next_st(expSt, 8'h0a), 8'h42);
    settle();
    repeat (30) begin
      b = 8'($random(seed));
      // bit 7 set only inside the forced pattern
      // no role input here, so every loopback code is legal
      if (b[7]) begin
        b[6:4] = 3'h7;
        b[1:0] = 2'b10;
      end
      apply(b);
    end
    // Strap selects default modes by pin level
    dualPortMode = 1'b1;
    u_host.tie(1'b0);
    expSt = 7'h40;
    settle();
    u_host.tie(1'b1);
    expSt = 7'h60;
    settle();
    complete_run();
  end
endmodule
